/* design/sysctl_regs.svh */
// Constants for the system control register, low half.
// Assumes inclusion by the package and design files by bare name.
`ifndef SYSCTL_REGS_SVH
`define SYSCTL_REGS_SVH

// ==========================================
// Transfer encoding that selects the register
`define SC_OPC1          3'h0
`define SC_CRN           4'h1
`define SC_CRM           4'h0
`define SC_OPC2          3'h0

// ==========================================
// Field positions
`define SC_BIT_TCM       16
`define SC_BIT_PCLS      15
`define SC_BIT_REPL      14
`define SC_BIT_V         13
`define SC_BIT_I         12
`define SC_BIT_Z         11
`define SC_BIT_F         10
`define SC_BIT_R         9
`define SC_BIT_S         8
`define SC_BIT_B         7
`define SC_RSV_HI        6
`define SC_RSV_LO        4
`define SC_BIT_W         3
`define SC_BIT_C         2
`define SC_BIT_A         1
`define SC_BIT_M         0

// ==========================================
// Constant read and reset values
`define SC_RSV_ONES      3'h7
`define SC_ONE           1'h1
`define SC_ZERO          1'h0
`define SC_HI_ZERO       15'h0000
`define SC_BANK_RST      8'h00
`define SC_SEC_RST       2'h0

// ==========================================
// Fixed high vector range
`define SC_HIVEC_BASE    32'hffff0000
`define SC_HIVEC_LAST    32'hffff001c

`endif

/* design/sysctl_pkg.sv */
// Types shared by the system control register files.
// Assumes the register constants header is on the include path.
package sysctl_pkg;
    `include "sysctl_regs.svh"

    // ==========================================
    // Coprocessor transfer request
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        priv;
        logic        secure;
        logic [2:0]  opc1;
        logic [3:0]  crn;
        logic [3:0]  crm;
        logic [2:0]  opc2;
        logic [31:0] wdata;
    } cp_req_s;

    // ==========================================
    // Banked field group, one copy per world
    typedef struct packed {
        logic v_hivec;
        logic i_cache;
        logic z_pred;
        logic r_rom;
        logic s_sys;
        logic c_cache;
        logic a_align;
        logic m_mmu;
    } bank_s;

    // ==========================================
    // Decoded access outcome
    typedef enum logic [1:0] {
        ACC_NONE  = 2'b00,
        ACC_READ  = 2'b01,
        ACC_WRITE = 2'b10,
        ACC_UNDEF = 2'b11
    } acc_e;
endpackage

/* design/sysctl_decode.sv */
// Access decoder for the system control register.
// Assumes a single request per cycle from the core, same clock.
module sysctl_decode
    import sysctl_pkg::*;
(
    // Request in
    input  wire sysctl_pkg::cp_req_s i_req,
    input  wire logic                i_lock,
    // Outcome
    output sysctl_pkg::acc_e         o_acc
);
    `include "sysctl_regs.svh"

    logic hit;

    // ==========================================
    // Encoding match and permission check
    always_comb begin
        hit = i_req.valid && i_req.opc1 == `SC_OPC1 && i_req.crn == `SC_CRN
              && i_req.crm == `SC_CRM && i_req.opc2 == `SC_OPC2;
        o_acc = ACC_NONE;
        if (hit) begin
            if (!i_req.priv) begin
                o_acc = ACC_UNDEF;
            end else if (i_req.write && i_req.secure && i_lock) begin
                o_acc = ACC_UNDEF;
            end else if (i_req.write) begin
                o_acc = ACC_WRITE;
            end else begin
                o_acc = ACC_READ;
            end
        end
    end
endmodule

/* design/sysctl_low.sv */
// System control register, low half (bits 16..0), with world banking.
// Assumes the core issues coprocessor transfers on i_mclk and that
// strap inputs come from pins, so they pass through synchronisers.
//
// Summary of operation
// - Bit 16 reads one, no function
// - Bit 15 PC-load state select, secure
// - Bit 14 replacement policy, secure only
// - Bit 13 banked high vector select
// - High vector reset from strap input
// - Bit 12 banked instruction cache enable
// - Bit 11 banked branch prediction enable
// - Bit 9 banked ROM protection
// - Bit 8 banked system protection
// - Bit 7 byte order, secure only
// - Byte order resets from endian straps
// - Bits 6 to 4 read ones
// - Bit 3 reads one, writes ignored
// - Bit 2 banked data cache enable
// - Bit 1 banked alignment check
// - Bit 0 banked MMU enable
// - Unprivileged access raises undefined exception
// - Locked secure write raises undefined
// - Non-secure writes skip secure-only fields
// - Secure-only fields read single copy
// - Banked fields keep two copies
// - Selected by opc1 0, c1, c0, 0
module sysctl_low
    import sysctl_pkg::*;
(
    // Clock and reset
    input  wire logic                i_mclk,
    input  wire logic                i_rst_n,
    // Coprocessor transfer
    input  wire sysctl_pkg::cp_req_s i_req,
    output logic                     o_rvalid,
    output logic [31:0]              o_rdata,
    output logic                     o_undef,
    // Straps and lock pins
    input  wire logic                i_high_vector_init,
    input  wire logic                i_big_endian_init,
    input  wire logic                i_unaligned_init,
    input  wire logic                i_secure_config_lock,
    // World of the running code
    input  wire logic                i_ns_state,
    // Enables to the core
    output logic                     o_pc_load_state_select,
    output logic                     o_replacement_policy_select,
    output logic                     o_high_vectors,
    output logic                     o_icache_en,
    output logic                     o_predict_en,
    output logic                     o_rom_prot,
    output logic                     o_sys_prot,
    output logic                     o_big_endian,
    output logic                     o_dcache_en,
    output logic                     o_align_check,
    output logic                     o_mmu_en
);
    import sysctl_pkg::*;

    // ==========================================
    // Pin synchronisers
    logic [3:0] pin_s1_q;
    logic [3:0] pin_s2_q;
    logic [3:0] pin_d;
    logic       vinit_s;
    logic       beinit_s;
    logic       uinit_s;
    logic       lock_s;

    always_comb begin
        pin_d = {i_secure_config_lock, i_unaligned_init,
                 i_big_endian_init, i_high_vector_init};
    end

    // Two flops per pin; only the second stage is read
    always_ff @(posedge i_mclk) begin
        pin_s1_q <= pin_d;
        pin_s2_q <= pin_s1_q;
    end

    always_comb begin
        vinit_s  = pin_s2_q[0];
        beinit_s = pin_s2_q[1];
        uinit_s  = pin_s2_q[2];
        lock_s   = pin_s2_q[3];
    end

    // ==========================================
    // Access decode
    acc_e acc;

    sysctl_decode u_decode (
        .i_req  (i_req),
        .i_lock (lock_s),
        .o_acc  (acc)
    );

    // ==========================================
    // Strap capture after reset release
    // A reset takes constants only; straps load on the first clock
    // after release, so the fields settle one cycle later.
    logic init_pend_q;
    logic init_pend_d;

    always_comb begin
        init_pend_d = 1'b0;
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            init_pend_q <= 1'b1;
        end else begin
            init_pend_q <= init_pend_d;
        end
    end

    // ==========================================
    // Register state
    bank_s sec_q;
    bank_s sec_d;
    bank_s ns_q;
    bank_s ns_d;
    logic  pcls_q;
    logic  pcls_d;
    logic  repl_q;
    logic  repl_d;
    logic  b_q;
    logic  b_d;
    bank_s wbank;
    logic  ns_acc;

    // Map write data into the banked layout
    always_comb begin
        wbank.v_hivec = i_req.wdata[`SC_BIT_V];
        wbank.i_cache = i_req.wdata[`SC_BIT_I];
        wbank.z_pred  = i_req.wdata[`SC_BIT_Z];
        wbank.r_rom   = i_req.wdata[`SC_BIT_R];
        wbank.s_sys   = i_req.wdata[`SC_BIT_S];
        wbank.c_cache = i_req.wdata[`SC_BIT_C];
        wbank.a_align = i_req.wdata[`SC_BIT_A];
        wbank.m_mmu   = i_req.wdata[`SC_BIT_M];
        ns_acc        = !i_req.secure;
    end

    // Next-state for all stored fields
    always_comb begin
        sec_d = sec_q;
        ns_d  = ns_q;
        pcls_d = pcls_q;
        repl_d = repl_q;
        b_d   = b_q;
        if (init_pend_q) begin
            sec_d.v_hivec = vinit_s;
            ns_d.v_hivec  = vinit_s;
            b_d = beinit_s && !uinit_s;
        end else if (acc == ACC_WRITE) begin
            if (ns_acc) begin
                ns_d = wbank;
            end else begin
                sec_d = wbank;
                pcls_d = i_req.wdata[`SC_BIT_PCLS];
                repl_d = i_req.wdata[`SC_BIT_REPL];
                b_d = i_req.wdata[`SC_BIT_B];
            end
        end
    end

    // Reset values; straps overwrite V and B on the next edge
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            sec_q <= `SC_BANK_RST;
            ns_q  <= `SC_BANK_RST;
            pcls_q <= `SC_ZERO;
            repl_q <= `SC_ZERO;
            b_q   <= `SC_ZERO;
        end else begin
            sec_q <= sec_d;
            ns_q  <= ns_d;
            pcls_q <= pcls_d;
            repl_q <= repl_d;
            b_q   <= b_d;
        end
    end

    // ==========================================
    // Read data assembly
    bank_s       rbank;
    logic [31:0] rword;

    always_comb begin
        rbank = ns_acc ? ns_q : sec_q;
        rword = 32'h0000_0000;
        rword[31:17]                 = `SC_HI_ZERO;
        rword[`SC_BIT_TCM]           = `SC_ONE;
        rword[`SC_BIT_PCLS]          = pcls_q;
        rword[`SC_BIT_REPL]          = repl_q;
        rword[`SC_BIT_B]             = b_q;
        rword[`SC_BIT_V]             = rbank.v_hivec;
        rword[`SC_BIT_I]             = rbank.i_cache;
        rword[`SC_BIT_Z]             = rbank.z_pred;
        rword[`SC_BIT_F]             = `SC_ZERO;
        rword[`SC_BIT_R]             = rbank.r_rom;
        rword[`SC_BIT_S]             = rbank.s_sys;
        rword[`SC_RSV_HI:`SC_RSV_LO] = `SC_RSV_ONES;
        rword[`SC_BIT_W]             = `SC_ONE;
        rword[`SC_BIT_C]             = rbank.c_cache;
        rword[`SC_BIT_A]             = rbank.a_align;
        rword[`SC_BIT_M]             = rbank.m_mmu;
    end

    // Answer registered one cycle after the request
    logic        rvalid_q;
    logic        rvalid_d;
    logic        undef_q;
    logic        undef_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    always_comb begin
        rvalid_d = (acc == ACC_READ);
        undef_d  = (acc == ACC_UNDEF);
        rdata_d  = (acc == ACC_READ) ? rword : rdata_q;
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            rvalid_q <= 1'b0;
            undef_q  <= 1'b0;
            rdata_q  <= 32'h0000_0000;
        end else begin
            rvalid_q <= rvalid_d;
            undef_q  <= undef_d;
            rdata_q  <= rdata_d;
        end
    end

    // ==========================================
    // Outputs to the core; banked fields follow the running world, secure-only fields do not
    // alignment over unaligned
    // The consumer gives o_align_check priority over unaligned support.
    bank_s live;

    always_comb begin
        live = i_ns_state ? ns_q : sec_q;
        o_rvalid                    = rvalid_q;
        o_rdata                     = rdata_q;
        o_undef                     = undef_q;
        o_pc_load_state_select      = pcls_q;
        o_replacement_policy_select = repl_q;
        o_high_vectors              = live.v_hivec;
        o_icache_en                 = live.i_cache;
        o_predict_en                = live.z_pred;
        o_rom_prot                  = live.r_rom;
        o_sys_prot                  = live.s_sys;
        o_big_endian                = b_q;
        o_dcache_en                 = live.c_cache;
        o_align_check               = live.a_align;
        o_mmu_en                    = live.m_mmu;
    end

    // ==========================================
    // Checks
    user_trap_a : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_req.valid && !i_req.priv && i_req.crn == `SC_CRN && i_req.crm == `SC_CRM
         && i_req.opc1 == `SC_OPC1 && i_req.opc2 == `SC_OPC2)
        |=> (o_undef && !o_rvalid && $stable(sec_q) && $stable(ns_q)))
        else $error("user access not trapped");

    lock_trap_a : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (acc == ACC_UNDEF && i_req.write) |=> ($stable(sec_q) && $stable(b_q)
         && $stable(pcls_q) && o_undef))
        else $error("locked write changed state");

    ns_skip_a : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (acc == ACC_WRITE && !i_req.secure && !init_pend_q)
        |=> ($stable(pcls_q) && $stable(repl_q) && $stable(b_q) && $stable(sec_q)))
        else $error("non-secure write touched secure state");

    rsv_ones_a : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        o_rvalid |-> (o_rdata[6:3] == 4'hf && o_rdata[16] && !o_rdata[10]))
        else $error("constant read bits wrong");

    bank_read_a : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (acc == ACC_READ && !i_req.secure && !init_pend_q)
        |=> (o_rdata[0] == $past(ns_q.m_mmu) && o_rdata[2] == $past(ns_q.c_cache)))
        else $error("non-secure read took wrong copy");

    sec_read_a : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (acc == ACC_READ) |=> (o_rdata[15] == $past(pcls_q) && o_rdata[7] == $past(b_q)))
        else $error("secure-only field misread");

    endian_init_a : assert property (@(posedge i_mclk)
        ($rose(i_rst_n) && init_pend_q) |=> (b_q == $past(beinit_s && !uinit_s)))
        else $error("byte order strap load wrong");

    vec_init_a : assert property (@(posedge i_mclk)
        ($rose(i_rst_n) && init_pend_q) |=> (sec_q.v_hivec == $past(vinit_s)
         && ns_q.v_hivec == $past(vinit_s)))
        else $error("vector strap load wrong");

    sec_write_a : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (acc == ACC_WRITE && i_req.secure && !init_pend_q)
        |=> (repl_q == $past(i_req.wdata[`SC_BIT_REPL])
             && sec_q.m_mmu == $past(i_req.wdata[`SC_BIT_M])))
        else $error("secure write not stored");

    // non-secure write lands in its own copy
    ns_write_a : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (acc == ACC_WRITE && !i_req.secure && !init_pend_q)
        |=> (ns_q.m_mmu == $past(i_req.wdata[`SC_BIT_M])
             && ns_q.c_cache == $past(i_req.wdata[`SC_BIT_C])))
        else $error("non-secure write not stored");

    // write buffer bit and high half are fixed
    wbuf_one_a : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        o_rvalid |-> (o_rdata[`SC_BIT_W] == `SC_ONE && o_rdata[31:17] == `SC_HI_ZERO))
        else $error("write buffer bit or high half wrong");
endmodule

/* bench/tb.sv */
// Self-checking bench for the system control register, low half.
// Assumes the package and constants header compile first; one clock domain.
`define CHK(got, exp, msg) begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
        errors++; \
        $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp); \
    end \
end

module tb;
    import sysctl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================
    // One row of ordinary traffic
    typedef struct {
        logic        wr, pv, sc;
        logic [3:0]  crn;
        logic [31:0] wd;
        logic        rv, un;
        logic [31:0] rd;
    } row_s;

    logic        i_mclk = 1'b0;
    logic        i_rst_n = 1'b0;
    cp_req_s     req = '0;
    logic        hv_init = 1'b1;
    logic        be_init = 1'b1;
    logic        ua_init = 1'b0;
    logic        lock = 1'b0;
    logic        ns_state = 1'b0;
    logic        o_rvalid, o_undef;
    logic [31:0] o_rdata;
    logic [10:0] en;
    int          errors = 0;
    int          n_compared = 0;

    // Rows assume straps high vector 1, big endian 1, unaligned 0 at reset
    row_s rows [18] = '{
        '{0, 1, 1, 4'h1, 32'h0, 1, 0, 32'h000120f8},
        '{0, 1, 0, 4'h1, 32'h0, 1, 0, 32'h000120f8},
        '{1, 1, 1, 4'h1, 32'hffffffff, 0, 0, 32'h0},
        '{0, 1, 1, 4'h1, 32'h0, 1, 0, 32'h0001fbff},
        '{0, 1, 0, 4'h1, 32'h0, 1, 0, 32'h0001e0f8},
        '{1, 1, 0, 4'h1, 32'h0, 0, 0, 32'h0},
        '{0, 1, 0, 4'h1, 32'h0, 1, 0, 32'h0001c0f8},
        '{0, 1, 1, 4'h1, 32'h0, 1, 0, 32'h0001fbff},
        '{1, 1, 1, 4'h1, 32'h0, 0, 0, 32'h0},
        '{0, 1, 1, 4'h1, 32'h0, 1, 0, 32'h00010078},
        '{1, 1, 0, 4'h1, 32'hffffffff, 0, 0, 32'h0},
        '{0, 1, 0, 4'h1, 32'h0, 1, 0, 32'h00013b7f},
        '{0, 1, 1, 4'h1, 32'h0, 1, 0, 32'h00010078},
        '{0, 0, 1, 4'h1, 32'h0, 0, 1, 32'h0},
        '{1, 0, 0, 4'h1, 32'hffffffff, 0, 1, 32'h0},
        '{1, 1, 1, 4'h2, 32'hffffffff, 0, 0, 32'h0},
        '{0, 1, 1, 4'h2, 32'h0, 0, 0, 32'h0},
        '{0, 1, 1, 4'h1, 32'h0, 1, 0, 32'h00010078}
    };

    sysctl_low i_dut (
        .i_mclk                      (i_mclk),
        .i_rst_n                     (i_rst_n),
        .i_req                       (req),
        .o_rvalid                    (o_rvalid),
        .o_rdata                     (o_rdata),
        .o_undef                     (o_undef),
        .i_high_vector_init          (hv_init),
        .i_big_endian_init           (be_init),
        .i_unaligned_init            (ua_init),
        .i_secure_config_lock        (lock),
        .i_ns_state                  (ns_state),
        .o_pc_load_state_select      (en[10]),
        .o_replacement_policy_select (en[9]),
        .o_high_vectors              (en[8]),
        .o_icache_en                 (en[7]),
        .o_predict_en                (en[6]),
        .o_rom_prot                  (en[5]),
        .o_sys_prot                  (en[4]),
        .o_big_endian                (en[3]),
        .o_dcache_en                 (en[2]),
        .o_align_check               (en[1]),
        .o_mmu_en                    (en[0])
    );

    // ==========================================
    // Clock, 4 ns period
    initial begin
        forever #2 i_mclk = ~i_mclk;
    end

    // Verdict and end of run, shared with the watchdog
    task automatic finish_test();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // One transfer, answer looked at in the cycle after the taking edge
    task automatic xfer(input row_s r);
        @(posedge i_mclk);
        req <= '{valid: 1'b1, write: r.wr, priv: r.pv, secure: r.sc, opc1: 3'h0,
                 crn: r.crn, crm: 4'h0, opc2: 3'h0, wdata: r.wd};
        @(posedge i_mclk);
        req.valid <= 1'b0;
        #1;
        `CHK(o_rvalid, r.rv, "read answer")
        `CHK(o_undef, r.un, "undefined trap")
        if (r.rv) `CHK(o_rdata, r.rd, "read word")
    endtask

    // Reset with given straps; straps settle long before release
    task automatic do_reset(input logic hv, input logic be, input logic ua);
        @(posedge i_mclk);
        i_rst_n <= 1'b0;
        hv_init <= hv;
        be_init <= be;
        ua_init <= ua;
        repeat (12) @(posedge i_mclk);
        #1;
        `CHK(o_rdata, 32'h0, "read data in reset")
        `CHK(o_rvalid, 1'b0, "answer in reset")
        @(posedge i_mclk);
        i_rst_n <= 1'b1;
        repeat (2) @(posedge i_mclk);
        #1;
        `CHK(en[8], hv, "high vectors after reset")
        `CHK(en[3], be & ~ua, "byte order after reset")
        `CHK({en[10:9], en[7:4], en[2:0]}, 9'h000, "enables after reset")
    endtask

    // ==========================================
    // Main sequence
    initial begin
        for (int k = 0; k < 4; k++) begin
            do_reset(~k[0], k[1], k[0]);
        end
        do_reset(1'b1, 1'b1, 1'b0);
        $display("test strap reset done");
        foreach (rows[k]) begin
            xfer(rows[k]);
        end
        $display("test table done");
        // Enables follow the world of the running code
        @(posedge i_mclk);
        ns_state <= 1'b1;
        @(posedge i_mclk);
        #1;
        `CHK(en, 11'h1f7, "non-secure enables")
        @(posedge i_mclk);
        ns_state <= 1'b0;
        @(posedge i_mclk);
        #1;
        `CHK(en, 11'h000, "secure enables")
        $display("test enables done");
        // Lock blocks secure writes only; sync lag of two cycles
        @(posedge i_mclk);
        lock <= 1'b1;
        repeat (4) @(posedge i_mclk);
        xfer('{1, 1, 1, 4'h1, 32'hffffffff, 0, 1, 32'h0});
        xfer('{0, 1, 1, 4'h1, 32'h0, 1, 0, 32'h00010078});
        xfer('{1, 1, 0, 4'h1, 32'h0, 0, 0, 32'h0});
        xfer('{0, 1, 0, 4'h1, 32'h0, 1, 0, 32'h00010078});
        @(posedge i_mclk);
        lock <= 1'b0;
        repeat (4) @(posedge i_mclk);
        $display("test lock done");
        // Back to back write then read sees the new word (whole-word write)
        // read-modify-write usage
        @(posedge i_mclk);
        req <= '{valid: 1'b1, write: 1'b1, priv: 1'b1, secure: 1'b1, opc1: 3'h0,
                 crn: 4'h1, crm: 4'h0, opc2: 3'h0, wdata: 32'hffffffff};
        @(posedge i_mclk);
        req.write <= 1'b0;
        @(posedge i_mclk);
        req.valid <= 1'b0;
        #1;
        `CHK(o_rvalid, 1'b1, "back to back answer")
        `CHK(o_rdata, 32'h0001fbff, "back to back word")
        `CHK(en, 11'h7ff & ~11'h008 | 11'h008, "enables after write")
        $display("test back to back done");
        finish_test();
    end

    // Watchdog, far beyond the under 200 cycles the tests take
    initial begin
        #40us;
        errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        finish_test();
    end
endmodule
